// ---- rsr_reset_source.sv ----
`timescale 1ns/1ps
// Reset cause and enable register with the reset sequencer around it.
// The external reset pin is only an input here: no internal source
// ever drives it.
module rsr_reset_source #(
    parameter int MCD_TIMEOUT_CYCLES = rsr_pkg::RSR_MCD_TIMEOUT_CYCLES,
    parameter int MCD_CNT_W = 16,
    parameter int HOLD_CYCLES = rsr_pkg::RSR_RESET_HOLD_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic external_pin_reset_n,
    input wire logic reset_comparator_out,
    input wire logic supply_above_threshold,
    input wire logic monitored_clock,
    input wire logic flash_error_event,
    input wire logic watchdog_overflow_event,
    output logic system_reset,
    output logic comparator_reset_enable,
    output logic missing_clock_enable,
    output logic supply_reset_enable
);

    // ------------------------------------------------------------------
    // Declarations.
    // ------------------------------------------------------------------
    logic [2:0] async_in;
    logic [2:0] sync_first;
    logic [2:0] sync_second;
    logic pin_low;
    logic cmp_low;
    logic supply_low;
    logic mcd_timeout;
    logic reg_write;
    logic sw_force;
    logic [6:0] next_cause;
    logic any_source;
    logic [6:0] cause;
    logic [7:0] hold_count;
    rsr_pkg::rsr_state_t state;

    localparam logic [7:0] HOLD_LAST = 8'(HOLD_CYCLES - 1);

    // ------------------------------------------------------------------
    // Synchronisers for the asynchronous inputs.
    // ------------------------------------------------------------------
    // The pin is sampled only, so internal sources leave it untouched.
    assign async_in = {supply_above_threshold, reset_comparator_out, external_pin_reset_n};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            // Two flops per input; the first is read only by the second.
            always_ff @(posedge core_clk or negedge reset_n) begin
                if (!reset_n) begin
                    sync_first[gi] <= 1'b1;
                    sync_second[gi] <= 1'b1;
                end else begin
                    sync_first[gi] <= async_in[gi];
                    sync_second[gi] <= sync_first[gi];
                end
            end
        end
    endgenerate

    assign pin_low = !sync_second[0];
    assign cmp_low = !sync_second[1];
    assign supply_low = !sync_second[2];

    // ------------------------------------------------------------------
    // Missing clock detector.
    // ------------------------------------------------------------------
    rsr_missing_clock #(
        .TIMEOUT_CYCLES(MCD_TIMEOUT_CYCLES),
        .CNT_W(MCD_CNT_W)
    ) u_missing_clock (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .monitored_clock(monitored_clock),
        .detector_enable(missing_clock_enable),
        .timeout_pulse(mcd_timeout)
    );

    // ------------------------------------------------------------------
    // Register write decode and the software force strobe.
    // ------------------------------------------------------------------
    assign reg_write = sfr_wr && (sfr_addr == rsr_pkg::RSR_CAUSE_ADDR) &&
        (state == rsr_pkg::RSR_ST_RUN);
    assign sw_force = reg_write && sfr_wdata[rsr_pkg::RSR_BIT_SW];

    // ------------------------------------------------------------------
    // Picks one cause by fixed priority so a single flag is set.
    // ------------------------------------------------------------------
    always_comb begin
        next_cause = '0;
        any_source = 1'b1;
        if (pin_low) begin
            next_cause[rsr_pkg::RSR_BIT_PIN] = 1'b1;
        end else if (supply_reset_enable && supply_low) begin
            next_cause[rsr_pkg::RSR_BIT_POWER] = 1'b1;
        end else if (mcd_timeout) begin
            next_cause[rsr_pkg::RSR_BIT_MCD] = 1'b1;
        end else if (comparator_reset_enable && cmp_low) begin
            next_cause[rsr_pkg::RSR_BIT_CMP] = 1'b1;
        end else if (watchdog_overflow_event) begin
            next_cause[rsr_pkg::RSR_BIT_WDT] = 1'b1;
        end else if (flash_error_event) begin
            next_cause[rsr_pkg::RSR_BIT_FLASH] = 1'b1;
        end else if (sw_force) begin
            next_cause[rsr_pkg::RSR_BIT_SW] = 1'b1;
        end else begin
            any_source = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Sequencer: holds the system in reset for a fixed time and for as long as
    // the pin or, when enabled, the supply stays low.
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= rsr_pkg::RSR_ST_HOLD;
            hold_count <= '0;
        end else begin
            case (state)
                rsr_pkg::RSR_ST_RUN: begin
                    hold_count <= '0;
                    if (any_source) begin
                        state <= rsr_pkg::RSR_ST_HOLD;
                    end
                end
                rsr_pkg::RSR_ST_HOLD: begin
                    if (pin_low || (supply_reset_enable && supply_low) ||
                        (comparator_reset_enable && cmp_low)) begin
                        hold_count <= '0;
                    end else if (hold_count == HOLD_LAST) begin
                        state <= rsr_pkg::RSR_ST_RUN;
                    end else begin
                        hold_count <= hold_count + 8'h01;
                    end
                end
                default: begin
                    state <= rsr_pkg::RSR_ST_HOLD;
                    hold_count <= '0;
                end
            endcase
        end
    end

    assign system_reset = (state == rsr_pkg::RSR_ST_HOLD);

    // ------------------------------------------------------------------
    // Cause flags: loaded whole on each new reset, power-on sets only
    // the power flag and clears the rest.
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cause <= rsr_pkg::RSR_CAUSE_POR_VALUE;
        end else if (state == rsr_pkg::RSR_ST_RUN && any_source) begin
            cause <= next_cause;
        end else if (state == rsr_pkg::RSR_ST_HOLD && pin_low) begin
            cause <= 7'h01;
        end
    end

    // ------------------------------------------------------------------
    // Enables: written by software, detector enables fall on reset.
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            comparator_reset_enable <= rsr_pkg::RSR_CMP_EN_RESET;
            missing_clock_enable <= rsr_pkg::RSR_MCD_EN_RESET;
            supply_reset_enable <= rsr_pkg::RSR_SUPPLY_EN_RESET;
        end else if (state == rsr_pkg::RSR_ST_HOLD) begin
            comparator_reset_enable <= rsr_pkg::RSR_CMP_EN_RESET;
            missing_clock_enable <= rsr_pkg::RSR_MCD_EN_RESET;
        end else if (reg_write) begin
            comparator_reset_enable <= sfr_wdata[rsr_pkg::RSR_BIT_CMP];
            missing_clock_enable <= sfr_wdata[rsr_pkg::RSR_BIT_MCD];
            supply_reset_enable <= sfr_wdata[rsr_pkg::RSR_BIT_POWER];
        end
    end

    // ------------------------------------------------------------------
    // Read data: registered one cycle after a read strobe.
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd && sfr_addr == rsr_pkg::RSR_CAUSE_ADDR) begin
            sfr_rdata <= {1'b0, cause};
        end else begin
            sfr_rdata <= 8'h00;
        end
    end

endmodule : rsr_reset_source

// ---- rsr_pkg.sv ----
// Functional notes
// - Bit 6 reads one after flash error reset.
// - Writing one to bit 5 enables comparator reset.
// - Bit 5 reads one after comparator reset.
// - Writing one to bit 4 forces reset.
// - Bit 4 reads one after software reset.
// - Bit 3 reads one after watchdog reset.
// - Writing one to bit 2 enables clock detector.
// - Bit 2 reads one after missing clock reset.
// - Writing one to bit 1 enables supply reset.
// - Bit 1 reads one after power-on/supply reset.
// - Power flag set makes other flags meaningless.
// - Bit 0 reads one after pin reset.
// - Bit 7 reads zero, writes ignored.
// - Stuck clock beyond timeout resets; zero disables.
// - Enabled comparator low holds device in reset; here the enable clears when reset begins, so reset ends after the fixed hold.
// - Internal resets never drive the reset pin.
package rsr_pkg;

    // ------------------------------------------------------------------
    // Register map and field positions.
    // ------------------------------------------------------------------
    localparam logic [7:0] RSR_CAUSE_ADDR = 8'hef;
    localparam int RSR_BIT_UNUSED = 7;
    localparam int RSR_BIT_FLASH = 6;
    localparam int RSR_BIT_CMP = 5;
    localparam int RSR_BIT_SW = 4;
    localparam int RSR_BIT_WDT = 3;
    localparam int RSR_BIT_MCD = 2;
    localparam int RSR_BIT_POWER = 1;
    localparam int RSR_BIT_PIN = 0;

    // ------------------------------------------------------------------
    // Values after power-on reset.
    // ------------------------------------------------------------------
    localparam logic [6:0] RSR_CAUSE_POR_VALUE = 7'h02;
    localparam logic RSR_CMP_EN_RESET = 1'b0;
    localparam logic RSR_MCD_EN_RESET = 1'b0;
    localparam logic RSR_SUPPLY_EN_RESET = 1'b1;

    // ------------------------------------------------------------------
    // Timing.
    // ------------------------------------------------------------------
    localparam int RSR_CLK_PERIOD_NS = 20;
    localparam int RSR_RESET_HOLD_CYCLES = 8;
    localparam int RSR_MCD_TIMEOUT_NS = 100000;
    localparam int RSR_MCD_TIMEOUT_CYCLES_RAW = RSR_MCD_TIMEOUT_NS / RSR_CLK_PERIOD_NS;
    localparam int RSR_MCD_TIMEOUT_CYCLES =
        (RSR_MCD_TIMEOUT_CYCLES_RAW < 1) ? 1 : RSR_MCD_TIMEOUT_CYCLES_RAW;

    // ------------------------------------------------------------------
    // Sequencer states.
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        RSR_ST_RUN = 2'b01,
        RSR_ST_HOLD = 2'b10
    } rsr_state_t;

endpackage : rsr_pkg

// ---- rsr_missing_clock.sv ----
`timescale 1ns/1ps
// Watches a monitored clock sampled on the core clock and pulses when
// it has stayed at one level for longer than the timeout.
module rsr_missing_clock #(
    parameter int TIMEOUT_CYCLES = 5000,
    parameter int CNT_W = 16
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic monitored_clock,
    input wire logic detector_enable,
    output logic timeout_pulse
);

    logic sync_first;
    logic sync_second;
    logic last_level;
    logic [CNT_W-1:0] stuck_count;

    localparam logic [CNT_W-1:0] LIMIT = CNT_W'(TIMEOUT_CYCLES);

    // ------------------------------------------------------------------
    // Two-stage synchroniser for the monitored clock.
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sync_first <= 1'b0;
            sync_second <= 1'b0;
        end else begin
            sync_first <= monitored_clock;
            sync_second <= sync_first;
        end
    end

    // ------------------------------------------------------------------
    // Counts cycles without an edge; a disabled detector stays idle.
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            last_level <= 1'b0;
            stuck_count <= '0;
            timeout_pulse <= 1'b0;
        end else begin
            last_level <= sync_second;
            timeout_pulse <= 1'b0;
            if (!detector_enable || sync_second != last_level) begin
                stuck_count <= '0;
            end else if (stuck_count == LIMIT) begin
                timeout_pulse <= 1'b1;
                stuck_count <= '0;
            end else begin
                stuck_count <= stuck_count + CNT_W'(1);
            end
        end
    end

endmodule : rsr_missing_clock

// ---- rsr_reset_source_checker.sv ----
`timescale 1ns/1ps
// Port-level checks of the reset cause register and its sequencer.
module rsr_reset_source_checker #(
    parameter int HOLD_CYCLES = 8
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic external_pin_reset_n,
    input wire logic reset_comparator_out,
    input wire logic supply_above_threshold,
    input wire logic monitored_clock,
    input wire logic flash_error_event,
    input wire logic watchdog_overflow_event,
    input wire logic system_reset,
    input wire logic comparator_reset_enable,
    input wire logic missing_clock_enable,
    input wire logic supply_reset_enable
);
    // ----------------------------------------
    // Clocking and shared sequences
    // ----------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    // A write to the cause register that the block takes.
    sequence s_reg_write;
        sfr_wr && sfr_addr == rsr_pkg::RSR_CAUSE_ADDR && !system_reset;
    endsequence

    // The hold of eight cycles, then release.
    sequence s_hold;
        system_reset [*8] ##1 !system_reset;
    endsequence

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    chk_sw_force_hold: assert property (s_reg_write ##0 sfr_wdata[4] |=> s_hold)
        else $error("Software reset hold is wrong.");
    chk_cmp_en_write: assert property (s_reg_write ##0 !sfr_wdata[4]
        |=> comparator_reset_enable == $past(sfr_wdata[5]))
        else $error("Comparator enable does not follow the write.");
    chk_mcd_en_write: assert property (s_reg_write ##0 !sfr_wdata[4]
        |=> missing_clock_enable == $past(sfr_wdata[2]))
        else $error("Clock detector enable does not follow the write.");
    chk_supply_en_write: assert property (s_reg_write ##0 !sfr_wdata[4]
        |=> supply_reset_enable == $past(sfr_wdata[1]))
        else $error("Supply enable does not follow the write.");
    chk_bit7_zero: assert property (sfr_rdata[7] == 1'b0)
        else $error("Unused bit reads one.");
    chk_rdata_idle: assert property (!(sfr_rd && sfr_addr == 8'hef) |=> sfr_rdata == 8'h00)
        else $error("Read data not zero without a read.");
    chk_cmp_low_reset: assert property ($fell(reset_comparator_out) &&
        comparator_reset_enable |-> ##[1:5] system_reset)
        else $error("Comparator low did not reset.");
    chk_pin_low_reset: assert property (!external_pin_reset_n |-> ##[0:4] system_reset)
        else $error("Pin low did not reset.");
    chk_wdt_pulse_reset: assert property (watchdog_overflow_event && !system_reset
        |=> system_reset)
        else $error("Watchdog overflow did not reset.");
    chk_flash_pulse_reset: assert property (flash_error_event && !system_reset
        |=> system_reset)
        else $error("Flash error did not reset.");
endmodule : rsr_reset_source_checker

// ---- rsr_reset_source_tb_top.sv ----
`timescale 1ns/1ps
module rsr_reset_source_tb_top;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata;
    logic external_pin_reset_n = 1'b1;
    logic reset_comparator_out = 1'b1;
    logic supply_above_threshold = 1'b1;
    logic monitored_clock = 1'b0;
    logic flash_error_event = 1'b0;
    logic watchdog_overflow_event = 1'b0;
    logic system_reset;
    logic comparator_reset_enable;
    logic missing_clock_enable;
    logic supply_reset_enable;
    logic mclk_run = 1'b1;
    logic rd_seen = 1'b0;
    logic [31:0] lfsr = 32'h0c89;
    logic [7:0] expq[$];
    int err_total = 0;
    int tests_run = 0;

    // Free-running core clock of 20 ns.
    always #10 core_clk = ~core_clk;

    rsr_reset_source #(.MCD_TIMEOUT_CYCLES(20), .MCD_CNT_W(16), .HOLD_CYCLES(8))
    i_rsr_reset_source (
        .core_clk(core_clk), .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .external_pin_reset_n(external_pin_reset_n),
        .reset_comparator_out(reset_comparator_out),
        .supply_above_threshold(supply_above_threshold), .monitored_clock(monitored_clock),
        .flash_error_event(flash_error_event),
        .watchdog_overflow_event(watchdog_overflow_event), .system_reset(system_reset),
        .comparator_reset_enable(comparator_reset_enable),
        .missing_clock_enable(missing_clock_enable),
        .supply_reset_enable(supply_reset_enable)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr_next

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: seen %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done

    task automatic reg_wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge core_clk);
        sfr_wr <= 1'b1;
        sfr_addr <= addr;
        sfr_wdata <= data;
        @(posedge core_clk);
        sfr_wr <= 1'b0;
    endtask : reg_wr

    // Issues a read and notes the expected byte for the monitor.
    task automatic reg_rd(input logic [7:0] addr, input logic [7:0] exp);
        @(posedge core_clk);
        sfr_rd <= 1'b1;
        sfr_addr <= addr;
        expq.push_back(exp);
        @(posedge core_clk);
        sfr_rd <= 1'b0;
    endtask : reg_rd

    // Waits, under a bound, for the system reset to reach a level.
    task automatic wait_rst(input logic val);
        int n;
        n = 0;
        while (system_reset !== val && n < 200) begin
            @(negedge core_clk);
            n++;
        end
        if (n == 200) begin
            err_total++;
            $display("MISMATCH at %0t: system reset wait ran out", $time);
            test_done();
        end
    endtask : wait_rst

    // Waits through a whole reset, then reads the recorded cause.
    task automatic trip(input string name, input logic [7:0] cause);
        wait_rst(1'b1);
        wait_rst(1'b0);
        reg_rd(8'hef, cause);
        $display("Test %s done", name);
    endtask : trip

    // Toggles the watched clock and tracks read strobes.
    always @(posedge core_clk) begin
        if (mclk_run) begin
            monitored_clock <= ~monitored_clock;
        end
        rd_seen <= sfr_rd;
    end

    // Compares read data with the oldest note the cycle after a read.
    always @(negedge core_clk) begin
        if (rd_seen) begin
            check(sfr_rdata, expq.pop_front());
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [7:0] ua;
        repeat (8) @(posedge core_clk);
        reset_n <= 1'b1;
        wait_rst(1'b0);
        check({5'h00, comparator_reset_enable, missing_clock_enable, supply_reset_enable}, 8'h01);
        reg_rd(8'hef, 8'h02);
        lfsr = lfsr_next(lfsr);
        ua = (lfsr[7:0] == 8'hef) ? 8'h00 : lfsr[7:0];
        reg_wr(ua, lfsr[15:8]);
        reg_rd(ua, 8'h00);
        $display("Test power-on done");
        reg_wr(8'hef, 8'h12);
        trip("software", 8'h10);
        check({5'h00, comparator_reset_enable, missing_clock_enable, supply_reset_enable}, 8'h01);
        @(posedge core_clk) watchdog_overflow_event <= 1'b1;
        @(posedge core_clk) watchdog_overflow_event <= 1'b0;
        trip("watchdog", 8'h08);
        @(posedge core_clk) flash_error_event <= 1'b1;
        @(posedge core_clk) flash_error_event <= 1'b0;
        trip("flash", 8'h40);
        @(posedge core_clk) external_pin_reset_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        external_pin_reset_n <= 1'b1;
        trip("pin", 8'h01);
        reg_wr(8'hef, 8'h22);
        @(negedge core_clk);
        check({5'h00, comparator_reset_enable, missing_clock_enable, supply_reset_enable}, 8'h05);
        @(posedge core_clk) reset_comparator_out <= 1'b0;
        wait_rst(1'b1);
        @(posedge core_clk) reset_comparator_out <= 1'b1;
        trip("comparator", 8'h20);
        reg_wr(8'hef, 8'h06);
        @(posedge core_clk) mclk_run <= 1'b0;
        trip("missing clock", 8'h04);
        mclk_run <= 1'b1;
        @(posedge core_clk) supply_above_threshold <= 1'b0;
        repeat (3) @(posedge core_clk);
        supply_above_threshold <= 1'b1;
        trip("supply", 8'h02);
        reg_wr(8'hef, 8'h80);
        @(posedge core_clk) mclk_run <= 1'b0;
        supply_above_threshold <= 1'b0;
        repeat (60) @(negedge core_clk);
        check({7'h00, system_reset}, 8'h00);
        check({5'h00, comparator_reset_enable, missing_clock_enable, supply_reset_enable}, 8'h00);
        reg_rd(8'hef, 8'h02);
        $display("Test disabled sources done");
        repeat (4) @(posedge core_clk);
        test_done();
    end
endmodule : rsr_reset_source_tb_top

bind rsr_reset_source rsr_reset_source_checker #(.HOLD_CYCLES(HOLD_CYCLES))
i_rsr_reset_source_checker (
    .core_clk(core_clk), .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .external_pin_reset_n(external_pin_reset_n), .reset_comparator_out(reset_comparator_out),
    .supply_above_threshold(supply_above_threshold), .monitored_clock(monitored_clock),
    .flash_error_event(flash_error_event), .watchdog_overflow_event(watchdog_overflow_event),
    .system_reset(system_reset), .comparator_reset_enable(comparator_reset_enable),
    .missing_clock_enable(missing_clock_enable), .supply_reset_enable(supply_reset_enable)
);
